// file: rtl/sacf_access_fsm.v
/*
 * setup access control state machine with an axi4-lite register slave.
 * assumes buttons and remote contact are raw pins (synchronised here),
 * buttons active high when pressed, remote contact low when grounded.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sacf_regs.vh"

module sacf_access_fsm #(
    parameter [31:0] HOLD_CYC = `SACF_HOLD_CYC,
    parameter [31:0] CHORD_CYC = `SACF_CHORD_CYC
) (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire btn_func,
    input wire btn_up,
    input wire btn_down,
    input wire remote_n,
    output reg [2:0] granted_level,
    output reg setup_active,
    output reg code_prompt,
    output reg end_message,
    output reg override_message,
    output reg [3:0] section_idx,
    output reg [3:0] function_idx,
    output reg editing
);

    // ************************************************************
    // states
    // ************************************************************
    localparam [2:0] ST_MEAS = 3'h0;
    localparam [2:0] ST_WAIT_CHORD = 3'h1;
    localparam [2:0] ST_CODE = 3'h2;
    localparam [2:0] ST_SECTION = 3'h3;
    localparam [2:0] ST_FUNCTION = 3'h4;
    localparam [2:0] ST_EDIT = 3'h5;
    localparam [2:0] ST_END = 3'h6;
    localparam [2:0] ST_RELEASE = 3'h7;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;
    reg [3:0] prev_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 4'h8;
            sync2_reg <= 4'h8;
            prev_reg <= 4'h8;
        end else begin
            sync1_reg <= {remote_n, btn_down, btn_up, btn_func};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    wire f_lvl = sync2_reg[0];
    wire chord = sync2_reg[1] & sync2_reg[2];
    wire up_rise = sync2_reg[1] & ~prev_reg[1] & ~sync2_reg[2];
    wire dn_rise = sync2_reg[2] & ~prev_reg[2] & ~sync2_reg[1];
    wire f_rise = f_lvl & ~prev_reg[0];
    wire f_fall = ~f_lvl & prev_reg[0];
    wire remote_act = ~sync2_reg[3];

    // ************************************************************
    // registers
    // ************************************************************
    reg [31:0] cfg_levels_reg;
    reg [31:0] cfg_pins_reg;
    reg [2:0] func_level_reg;
    wire [2:0] quick_access_level = cfg_levels_reg[`SACF_QUICK_LSB +: 3];
    wire [2:0] remote_access_level = cfg_levels_reg[`SACF_REMOTE_LSB +: 3];
    wire [2:0] pin_one_level = cfg_levels_reg[`SACF_PIN1_LSB +: 3];
    wire [2:0] pin_two_level = cfg_levels_reg[`SACF_PIN2_LSB +: 3];
    wire remote_input_access_function = cfg_levels_reg[`SACF_REMEN_BIT];
    wire [15:0] pin_one_value = cfg_pins_reg[`SACF_PINV1_LSB +: 16];
    wire [15:0] pin_two_value = cfg_pins_reg[`SACF_PINV2_LSB +: 16];

    // ************************************************************
    // main state machine
    // ************************************************************
    reg [2:0] state_reg;
    reg [31:0] cnt_reg;
    reg [15:0] code_reg;
    reg override_reg;
    reg [1:0] boot_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_MEAS;
            cnt_reg <= 32'h0000_0000;
            code_reg <= 16'h0000;
            granted_level <= `SACF_LVL_NONE;
            override_reg <= 1'b0;
            boot_reg <= 2'h3;
            section_idx <= 4'h0;
            function_idx <= 4'h0;
        end else begin
            case (state_reg)
            ST_MEAS: begin
                // power-up hold: first sample through the synchroniser, third edge
                if (boot_reg != 2'h0) begin
                    if (boot_reg == 2'h1 && f_lvl) begin
                        override_reg <= 1'b1;
                    end
                    boot_reg <= boot_reg - 2'h1;
                end
                if (f_lvl) begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                    if (!override_reg && cnt_reg == HOLD_CYC - 32'h0000_0001) begin
                        // remote contact wins over the plain quick route
                        if (remote_input_access_function && remote_act) begin
                            granted_level <= remote_access_level;
                        end else begin
                            granted_level <= quick_access_level;
                        end
                        state_reg <= (remote_input_access_function && remote_act) ||
                            quick_access_level != `SACF_LVL_NONE ? ST_SECTION : ST_END;
                        cnt_reg <= 32'h0000_0000;
                    end
                end else if (f_fall) begin
                    state_reg <= ST_WAIT_CHORD;
                    cnt_reg <= 32'h0000_0000;
                end else begin
                    cnt_reg <= 32'h0000_0000;
                end
            end
            ST_WAIT_CHORD: begin
                cnt_reg <= cnt_reg + 32'h0000_0001;
                if (chord) begin
                    cnt_reg <= 32'h0000_0000;
                    code_reg <= 16'h0000;
                    if (override_reg) begin
                        granted_level <= `SACF_LVL_CAL;
                        state_reg <= ST_SECTION;
                    end else if (pin_one_level == `SACF_LVL_NONE) begin
                        granted_level <= pin_one_level;
                        state_reg <= ST_END;
                    end else if (pin_one_value == 16'h0000 && pin_two_value == 16'h0000) begin
                        granted_level <= pin_one_level;
                        state_reg <= ST_SECTION;
                    end else begin
                        state_reg <= ST_CODE;
                    end
                end else if (cnt_reg >= CHORD_CYC - 32'h0000_0001) begin
                    state_reg <= ST_MEAS;
                    cnt_reg <= 32'h0000_0000;
                end
            end
            ST_CODE: begin
                if (up_rise) begin
                    code_reg <= code_reg + 16'h0001;
                end else if (dn_rise) begin
                    code_reg <= code_reg - 16'h0001;
                end else if (f_rise) begin
                    if (code_reg == pin_one_value) begin
                        granted_level <= pin_one_level;
                        state_reg <= ST_SECTION;
                    end else if (code_reg == pin_two_value) begin
                        granted_level <= pin_two_level;
                        state_reg <= ST_SECTION;
                    end else begin
                        state_reg <= ST_END;
                    end
                end
            end
            ST_SECTION: begin
                if (up_rise) begin
                    section_idx <= section_idx + 4'h1;
                end else if (dn_rise) begin
                    section_idx <= section_idx - 4'h1;
                end else if (f_rise) begin
                    function_idx <= 4'h0;
                    state_reg <= ST_FUNCTION;
                end
            end
            ST_FUNCTION: begin
                if (up_rise) begin
                    function_idx <= function_idx + 4'h1;
                end else if (dn_rise) begin
                    function_idx <= function_idx - 4'h1;
                end else if (f_rise) begin
                    // functions above the granted level stay locked
                    if (granted_level == `SACF_LVL_CAL || override_reg ||
                        func_level_reg <= granted_level) begin
                        state_reg <= ST_EDIT;
                    end
                end
            end
            ST_EDIT: begin
                if (f_rise) begin
                    state_reg <= ST_FUNCTION;
                end
            end
            ST_END: begin
                // one cycle of end message, then wait for buttons to settle
                granted_level <= `SACF_LVL_NONE;
                state_reg <= ST_RELEASE;
            end
            ST_RELEASE: begin
                if (!f_lvl && !sync2_reg[1] && !sync2_reg[2]) begin
                    state_reg <= ST_MEAS;
                end
            end
            default: state_reg <= ST_MEAS;
            endcase
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            setup_active <= 1'b0;
            code_prompt <= 1'b0;
            end_message <= 1'b0;
            override_message <= 1'b0;
            editing <= 1'b0;
        end else begin
            setup_active <= state_reg == ST_SECTION || state_reg == ST_FUNCTION ||
                state_reg == ST_EDIT;
            code_prompt <= state_reg == ST_CODE;
            end_message <= state_reg == ST_END;
            override_message <= override_reg;
            editing <= state_reg == ST_EDIT;
        end
    end

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [5:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    wire wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    integer i;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 6'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            cfg_levels_reg <= `SACF_CFG_LEVELS_RST;
            cfg_pins_reg <= `SACF_CFG_PINS_RST;
            func_level_reg <= 3'h0;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr[5:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (awaddr_reg)
                `SACF_CFG_LEVELS: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (wstrb_reg[i]) begin
                            cfg_levels_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
                        end
                    end
                end
                `SACF_CFG_PINS: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (wstrb_reg[i]) begin
                            cfg_pins_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
                        end
                    end
                end
                `SACF_FUNC_LEVEL: begin
                    if (wstrb_reg[0]) begin
                        func_level_reg <= wdata_reg[2:0];
                    end
                end
                `SACF_STATUS, `SACF_NAV: s_axi_bresp <= 2'h0;
                default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr[5:0])
                `SACF_CFG_LEVELS: s_axi_rdata <= cfg_levels_reg;
                `SACF_CFG_PINS: s_axi_rdata <= cfg_pins_reg;
                `SACF_STATUS: s_axi_rdata <= {22'h000000, override_reg, state_reg,
                    end_message, code_prompt, setup_active, granted_level};
                `SACF_NAV: s_axi_rdata <= {23'h000000, editing, function_idx,
                    section_idx};
                `SACF_FUNC_LEVEL: s_axi_rdata <= {29'h00000000, func_level_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/sacf_regs.vh
/*
 * constants for the setup access control state machine: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz aclk and an axi4-lite master that issues word accesses.
 */
// Notes on behaviour
// - function button held 3 s enters quick level
// - quick level resets none; press then refused
// - remote route needs access input grounded
// - remote level resets to calibration
// - both pin codes zero skip code prompt
// - active pin shows code prompt first
// - code matching pin one or two grants
// - grant unlocks functions at or below level
// - wrong code shows end, back to measure
// - power-up hold then chord grants everything
// - up/down pick section then function
// - levels none,1..6,calibration ordered
`ifndef SACF_REGS_VH
`define SACF_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define SACF_CFG_LEVELS 6'h00
`define SACF_CFG_PINS 6'h04
`define SACF_STATUS 6'h08
`define SACF_NAV 6'h0C
`define SACF_FUNC_LEVEL 6'h10

// ************************************************************
// access level encodings
// ************************************************************
`define SACF_LVL_NONE 3'h0
`define SACF_LVL_CAL 3'h7

// ************************************************************
// field positions
// ************************************************************
`define SACF_QUICK_LSB 0
`define SACF_REMOTE_LSB 4
`define SACF_PIN1_LSB 8
`define SACF_PIN2_LSB 12
`define SACF_REMEN_BIT 16
`define SACF_PINV1_LSB 0
`define SACF_PINV2_LSB 16

// ************************************************************
// reset values
// ************************************************************
`define SACF_CFG_LEVELS_RST 32'h0000_0070
`define SACF_CFG_PINS_RST 32'h0000_0000

// ************************************************************
// timing
// ************************************************************
`define SACF_CLK_HZ 100000000
`define SACF_HOLD_MS 3000
`define SACF_CHORD_MS 2000
`define SACF_HOLD_CYC ((`SACF_CLK_HZ / 1000) * `SACF_HOLD_MS)
`define SACF_CHORD_CYC ((`SACF_CLK_HZ / 1000) * `SACF_CHORD_MS)

`endif

// file: testbench/sacf_access_fsm_monitor.sv
/*
 * port-level checker for the setup access state machine.
 * assumes it is bound to sacf_access_fsm and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sacf_regs.vh"
module sacf_access_fsm_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [2:0] granted_level,
    input wire setup_active,
    input wire code_prompt,
    input wire end_message,
    input wire override_message,
    input wire [3:0] section_idx,
    input wire [3:0] function_idx,
    input wire editing
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ********************************
    // access and navigation
    // ********************************
    end_pulse_a: assert property (end_message |=> !end_message)
        else $error("end message longer than one cycle");
    end_refuses_a: assert property (end_message |-> !setup_active &&
        granted_level == `SACF_LVL_NONE) else $error("end message with access");
    grant_nonzero_a: assert property (setup_active |->
        granted_level != `SACF_LVL_NONE) else $error("setup with no level");
    grant_hold_a: assert property (setup_active |=>
        setup_active && $stable(granted_level)) else $error("granted level moved");
    prompt_first_a: assert property (code_prompt |-> !setup_active)
        else $error("setup reachable during code prompt");
    prompt_ends_a: assert property ($fell(code_prompt) |->
        ##[0:3] (setup_active || end_message)) else $error("code prompt left silently");
    nav_idle_a: assert property (!setup_active |-> section_idx == 4'h0 &&
        function_idx == 4'h0 && !editing) else $error("navigation outside setup");
    override_keep_a: assert property (override_message |=>
        override_message) else $error("override message dropped");
    bvalid_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    rvalid_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data withdrawn");
endmodule
bind sacf_access_fsm sacf_access_fsm_monitor sacf_access_fsm_monitor_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .granted_level(granted_level),
    .setup_active(setup_active), .code_prompt(code_prompt), .end_message(end_message),
    .override_message(override_message), .section_idx(section_idx),
    .function_idx(function_idx), .editing(editing)
);
`default_nettype wire

// file: testbench/sacf_operator_model.sv
/*
 * operator model: function, up and down buttons and the remote contact.
 * assumes its tasks are called just after a rising edge of aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module sacf_operator_model (
    input wire aclk,
    output logic btn_func,
    output logic btn_up,
    output logic btn_down,
    output logic remote_n
);
    // contact has a pull-up, so an open contact reads high
    initial begin
        {btn_func, btn_up, btn_down} = 3'h0;
        remote_n = 1'b1;
    end
    // mask is {func, up, down}; settle time covers the input synchroniser
    task automatic push(input logic [2:0] m, input int n);
        {btn_func, btn_up, btn_down} <= m;
        repeat (n) @(posedge aclk);
        {btn_func, btn_up, btn_down} <= 3'h0;
        repeat (6) @(posedge aclk);
    endtask
    task automatic contact(input logic on);
        remote_n <= !on;
    endtask
    task automatic hold_func(input logic on);
        btn_func <= on;
    endtask
    // gap makes the operator prompt or slow
    task automatic pin_entry(input int gap);
        push(3'h4, 3);
        repeat (gap) @(posedge aclk);
        push(3'h3, 4);
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
 * self-checking bench for the setup access state machine.
 * assumes the operator model and the bound checker; hold and chord counts shortened.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sacf_regs.vh"
module tb_top;
    localparam int HOLD = 40;
    localparam int CHORD = 20;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, act, prm, endm, ovr, edt;
    wire bf, bu, bd, rn;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [2:0] lvl;
    wire [3:0] sec, fn;
    int num_errors = 0, cmp_count = 0, seed = 28, cyc = 0, ends = 0;
    sacf_access_fsm #(.HOLD_CYC(HOLD), .CHORD_CYC(CHORD)) sacf_access_fsm_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .btn_func(bf), .btn_up(bu), .btn_down(bd), .remote_n(rn), .granted_level(lvl),
        .setup_active(act), .code_prompt(prm), .end_message(endm),
        .override_message(ovr), .section_idx(sec), .function_idx(fn), .editing(edt));
    sacf_operator_model op (.aclk(aclk), .btn_func(bf), .btn_up(bu), .btn_down(bd),
        .remote_n(rn));
    initial begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (endm === 1'b1)
            ends <= ends + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    // ********************************
    // tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // mid-run resets are the only way out of setup
    task automatic do_reset(input logic hold);
        aresetn <= 1'b0;
        op.hold_func(hold);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk(bresp, er);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic cfg(input logic [2:0] q, r, a, b, input logic en,
                       input logic [15:0] p, s);
        wr(`SACF_CFG_LEVELS, {15'h0, en, 1'b0, b, 1'b0, a, 1'b0, r, 1'b0, q}, 2'h0);
        wr(`SACF_CFG_PINS, {s, p}, 2'h0);
    endtask
    // a function opens when calibration is granted or its level is within the grant
    function automatic logic exp_open(input logic [2:0] lv, input logic [2:0] fl);
        return lv == `SACF_LVL_CAL || fl <= lv;
    endfunction
    task automatic nav(input logic [2:0] lv);
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] fl;
        fl = 3'($random(seed));
        op.push(3'h2, 3);
        op.push(3'h2, 3);
        chk(sec, 4'h2);
        op.push(3'h1, 3);
        chk(sec, 4'h1);
        op.push(3'h4, 3);
        op.push(3'h2, 3);
        chk(fn, 4'h1);
        wr(`SACF_FUNC_LEVEL, {29'h0, fl}, 2'h0);
        rd(`SACF_FUNC_LEVEL, d, r);
        chk(d, {29'h0, fl});
        op.push(3'h4, 3);
        chk(edt, exp_open(lv, fl));
    endtask
    // ********************************
    // tests
    // ********************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] q;
        logic [15:0] p1, p2;
        int e;
        do_reset(1'b0);
        rd(`SACF_CFG_LEVELS, d, r);
        chk(d, `SACF_CFG_LEVELS_RST);
        chk(d[`SACF_REMOTE_LSB +: 3], `SACF_LVL_CAL);
        chk(d[2:0], `SACF_LVL_NONE);
        rd(32'h14, d, r);
        chk(r, 2'h2);
        wr(32'h20, 32'h1, 2'h2);
        e = ends;
        op.push(3'h4, HOLD + 8);
        chk(ends, e + 1);
        chk(act, 1'b0);
        $display("registers and refused press done");
        q = 3'h1 + 3'(($random(seed) & 255) % 6);
        // 0: contact open, 1: contact closed, 2: route off with contact closed
        for (int i = 0; i < 3; i++) begin
            do_reset(1'b0);
            cfg(q, `SACF_LVL_CAL, 3'h0, 3'h0, i != 2, 16'h0, 16'h0);
            op.contact(i != 0);
            fork
                op.push(3'h4, HOLD + 8);
                begin
                    repeat (HOLD - 4) @(posedge aclk);
                    chk(act, 1'b0);
                end
            join
            chk(act, 1'b1);
            chk(lvl, (i == 1) ? `SACF_LVL_CAL : q);
            nav((i == 1) ? `SACF_LVL_CAL : q);
            op.contact(1'b0);
        end
        $display("long press routes done");
        // 0: first code, 1: second code, 2: wrong code
        for (int k = 0; k < 3; k++) begin
            do_reset(1'b0);
            p1 = 16'h1 + 16'($random(seed) & 3);
            p2 = p1 + 16'h1 + 16'($random(seed) & 3);
            cfg(3'h0, `SACF_LVL_CAL, 3'h2, 3'h5, 1'b0, p1, p2);
            op.pin_entry($random(seed) & 7);
            chk(prm, 1'b1);
            chk(act, 1'b0);
            e = ends;
            repeat ((k == 0) ? p1 : (k == 1) ? p2 : p2 + 16'h1) op.push(3'h2, 3);
            op.push(3'h4, 3);
            chk(lvl, (k == 0) ? 3'h2 : (k == 1) ? 3'h5 : 3'h0);
            chk(ends, e + (k == 2));
            chk(act, k != 2);
        end
        $display("code entry done");
        do_reset(1'b0);
        // pin one level still at its reset value of none: route refused
        e = ends;
        op.pin_entry(0);
        chk(ends, e + 1);
        chk(act, 1'b0);
        cfg(3'h0, `SACF_LVL_CAL, 3'h4, 3'h0, 1'b0, 16'h0, 16'h0);
        op.pin_entry(CHORD + 10);
        chk(prm, 1'b0);
        chk(act, 1'b0);
        op.pin_entry(0);
        chk(prm, 1'b0);
        chk(lvl, 3'h4);
        chk(act, 1'b1);
        $display("chord window and open pin done");
        do_reset(1'b1);
        repeat (3) @(posedge aclk);
        chk(ovr, 1'b1);
        op.hold_func(1'b0);
        repeat (CHORD + 10) @(posedge aclk);
        op.pin_entry(2);
        chk(lvl, `SACF_LVL_CAL);
        chk(act, 1'b1);
        $display("power-up override done");
        final_report();
    end
endmodule
`default_nettype wire
